// >>> bench/strap_board.sv
`default_nettype none
module strap_board #(
	parameter logic MIDDLE = 1'b0
) (
	// Strap choice.
	input  wire logic [6:0] tie_i,
	// Pins to the chip.
	output logic      [6:0] strap_o,
	// High while the choice is one that a real board may strap.
	output logic            legal_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Straps are fixed wiring; an open pad reads low through its pull-down.
	assign strap_o = tie_i;
	// Inner chips never use the all-ones nibble, outer chips never the all-ones position.
	// A middle layer stave only has four modules, so its index stops at four.
	assign legal_o = (tie_i[6:4] == 3'h0) ? (tie_i[3:0] != 4'hf)
		: ((tie_i[2:0] != 3'h7) && (!MIDDLE || (tie_i[6:4] <= 3'h4)));
endmodule
`default_nettype wire

// >>> bench/tb_chip_role_address_decode.sv
`default_nettype none
module tb_chip_role_address_decode
	import role_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [6:0]  tie = 7'h00;
	logic [6:0]  strap, address_o;
	logic [7:0]  id_byte_i = 8'h00;
	logic        id_valid_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [3:0]  wb_sel_i = 4'hf;
	logic        legal;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	role_e       role_o;
	logic [2:0]  mod_index_o;
	logic        row_select_bit_o, strap_reserved_o, differential_control_port_en_o;
	logic        single_ended_port_en_o, write_accept_o, wb_ack_o;
	int          num_errors = 0;
	int          n_compared = 0;

	strap_board u_board (.tie_i(tie), .strap_o(strap), .legal_o(legal));
	chip_role_address_decode u_dut (.clk_i, .rst_i, .identity_strap_bus_i(strap),
		.id_byte_i, .id_valid_i, .address_o, .role_o, .mod_index_o, .row_select_bit_o,
		.strap_reserved_o, .differential_control_port_en_o, .single_ended_port_en_o,
		.write_accept_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o);

	////////////////////////////////////////////////////////////////////////////
	// Shared helpers.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("errors=%0d compared=%0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// One classic cycle; the master waits for ack, then checks the one-cycle latency.
	task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1);
		chk(n, 32'h2);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// One identification byte, judged on the cycle after it is taken.
	task automatic send(input logic [7:0] b, input logic exp);
		@(posedge clk_i);
		id_valid_i <= 1'b1;
		id_byte_i <= b;
		@(posedge clk_i);
		id_valid_i <= 1'b0;
		#1;
		chk(write_accept_o, exp);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_decode;
		logic [16:0] seen, want;
		logic [2:0]  ro;
		logic        in, rv;
		for (int i = 0; i < 128; i++) begin
			@(posedge clk_i);
			tie <= i[6:0];
			repeat (2) @(posedge clk_i);
			#1;
			in = (i[6:4] == 3'h0);
			ro = in ? 3'b001 : ((i[2:0] == 3'h0) ? 3'b010 : 3'b100);
			rv = in ? (i[3:0] == 4'hf) : (i[2:0] == 3'h7);
			seen = {address_o, role_o, mod_index_o, row_select_bit_o, strap_reserved_o,
				differential_control_port_en_o, single_ended_port_en_o};
			want = {i[6:0], ro, i[6:4], ~in & i[3], rv, ~ro[2], ~ro[0]};
			chk(seen, want);
			chk(strap_reserved_o, !legal);
		end
	endtask

	// Outer slave on row one of module two, then an inner chip.
	task automatic t_match;
		@(posedge clk_i);
		tie <= 7'h2a;
		repeat (2) @(posedge clk_i);
		send(8'h2a, 1'b1);
		send(8'h2b, 1'b0);
		send(8'h0f, 1'b1);
		send(8'h2f, 1'b1);
		send(8'h27, 1'b0);
		@(posedge clk_i);
		tie <= 7'h05;
		repeat (2) @(posedge clk_i);
		send(8'h0f, 1'b1);
		send(8'h05, 1'b1);
	endtask

	// Five writes were accepted before this point.
	task automatic t_regs;
		wb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h1);
		wb(1'b0, OFS_HIT_COUNT, 32'h0);
		chk(rd, 32'h5);
		wb(1'b1, OFS_STATUS, 32'hffff_ffff);
		wb(1'b0, OFS_STATUS, 32'h0);
		chk(rd, 32'h85);
		wb(1'b0, 4'hc, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, OFS_CONTROL, 32'h0);
		send(8'h0f, 1'b0);
		wb(1'b1, OFS_CONTROL, 32'h1);
		send(8'h05, 1'b1);
		wb(1'b0, OFS_HIT_COUNT, 32'h0);
		chk(rd, 32'h6);
		// A control write without its low byte lane must leave matching on.
		wb_sel_i <= 4'he;
		wb(1'b1, OFS_CONTROL, 32'h0);
		wb_sel_i <= 4'hf;
		wb(1'b0, OFS_CONTROL, 32'h0);
		chk(rd, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Clock, reset, sequence and watchdog.
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_decode;
		t_match;
		t_regs;
		print_verdict;
	end

	// The sequence needs well under a thousand cycles.
	initial begin
		#50000;
		num_errors++;
		print_verdict;
	end
endmodule
`default_nettype wire

// >>> hw/chip_role_address_decode.sv
// Our own choices: the register offsets and the Wishbone interface to the registers.
`default_nettype none
// Contract
// - The seven strap bits pick the operating role and are also the chip's control address.
// - A zero module index makes the chip an inner barrel chip.
// - A non-zero module index puts the chip in an outer barrel role.
// - In outer barrel roles bit three tells which of the two rows holds the chip.
// - In outer barrel roles a zero low three bits make the chip module master.
// - In outer barrel roles any other low three bits make the chip a module slave.
// - Inner uses only the differential port, master both ports, slave only single-ended.
// - A write to the global broadcast byte is taken by every chip.
// - A write to zero, module index, row bit, three ones is taken by that row's chips.
module chip_role_address_decode
	import role_pkg::*;
(
	// Clock and reset.
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	// Board straps.
	input  wire logic [ID_W-1:0] identity_strap_bus_i,
	// Chip identification byte of an incoming write.
	input  wire logic [7:0]      id_byte_i,
	input  wire logic            id_valid_i,
	// Decoded role and address, and the write accept pulse.
	output logic [ID_W-1:0]      address_o,
	output role_e                role_o,
	output logic [2:0]           mod_index_o,
	output logic                 row_select_bit_o,
	output logic                 strap_reserved_o,
	output logic                 differential_control_port_en_o,
	output logic                 single_ended_port_en_o,
	output logic                 write_accept_o,
	// Wishbone slave.
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [3:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic [31:0]          wb_dat_o,
	output logic                 wb_ack_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Strap sampling and role decode.

	logic [ID_W-1:0]  ident;
	logic             match_en;
	logic [HIT_W-1:0] hit_count;
	decoded_s         dec;

	// Straps are re-read every cycle, so a re-strapped board is followed without a reset.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ident <= IDENT_RESET;
		end else begin
			ident <= identity_strap_bus_i;
		end
	end

	// Reserved codes are flagged but not refused: the board is trusted, software can check.
	assign dec.role           = role_f(ident);
	assign dec.mod_index      = mod_index_f(ident);
	assign dec.row_select_bit = ident[ROW_BIT];
	assign dec.position       = ident[ROW_BIT:POS_LO];
	assign dec.reserved_code  = (dec.role == ROLE_INNER) ? (ident[3:0] == IB_RESERVED)
		: (ident[POS_HI:POS_LO] == POS_RESERVED);

	// Role and address outputs straight from the sampled register.
	assign address_o        = ident;
	assign role_o           = dec.role;
	assign mod_index_o      = dec.mod_index;
	assign row_select_bit_o = (dec.role != ROLE_INNER) && dec.row_select_bit;
	assign strap_reserved_o = dec.reserved_code;

	// Port selection per role.
	assign differential_control_port_en_o = (dec.role != ROLE_OB_SLAVE);
	assign single_ended_port_en_o         = (dec.role != ROLE_INNER);

	////////////////////////////////////////////////////////////////////////////////
	// Write address matching.

	wire logic hit_uni;
	wire logic hit_bcast;
	wire logic hit_mcast;

	id_match u_match (
		.ident_i     (ident),
		.dec_i       (dec),
		.id_byte_i   (id_byte_i),
		.unicast_o   (hit_uni),
		.broadcast_o (hit_bcast),
		.multicast_o (hit_mcast)
	);

	wire logic next_accept = id_valid_i && match_en && (hit_uni || hit_bcast || hit_mcast);

	// Accept pulse is registered one cycle after the byte, with a saturating hit counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			write_accept_o <= 1'b0;
			hit_count      <= '0;
		end else begin
			write_accept_o <= next_accept;
			if (next_accept && (hit_count != {HIT_W{1'b1}})) begin
				hit_count <= hit_count + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone register file.

	wire logic req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic sel_stat = (wb_adr_i == OFS_STATUS);
	wire logic sel_ctl  = (wb_adr_i == OFS_CONTROL);
	wire logic sel_hit  = (wb_adr_i == OFS_HIT_COUNT);
	wire logic ctl_wr   = req && wb_we_i && sel_ctl && wb_sel_i[0];

	wire logic [31:0] status_word = {21'h0, dec.reserved_code, dec.role, ident};
	wire logic [31:0] rd_mux = sel_stat ? status_word
		: sel_ctl ? {31'h0, match_en}
		: sel_hit ? {16'h0, hit_count}
		: 32'h0;

	// Single wait-free answer: ack one cycle after the request, dropped the next.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			match_en <= MATCH_EN_RESET;
		end else begin
			wb_ack_o <= req;
			if (req) begin
				wb_dat_o <= rd_mux;
			end
			if (ctl_wr) begin
				match_en <= wb_dat_i[CTL_MATCH_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions.

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ident_follows;
		##1 ident == $past(identity_strap_bus_i);
	endproperty
	a_ident_follows: assert property (p_ident_follows) else $error("identity not sampled");

	property p_onehot;
		$onehot(role_o) && address_o == ident;
	endproperty
	a_onehot: assert property (p_onehot) else $error("role not one-hot");

	property p_inner;
		(identity_strap_bus_i[6:4] == 3'h0) |=> (role_o == ROLE_INNER);
	endproperty
	a_inner: assert property (p_inner) else $error("inner role not chosen");

	property p_outer;
		(identity_strap_bus_i[6:4] != 3'h0) |=> (role_o != ROLE_INNER);
	endproperty
	a_outer: assert property (p_outer) else $error("outer role not chosen");

	property p_master;
		(identity_strap_bus_i[6:4] != 3'h0 && identity_strap_bus_i[2:0] == 3'h0)
			|=> (role_o == ROLE_OB_MASTER);
	endproperty
	a_master: assert property (p_master) else $error("master role not chosen");

	property p_slave;
		(identity_strap_bus_i[6:4] != 3'h0 && identity_strap_bus_i[2:0] != 3'h0)
			|=> (role_o == ROLE_OB_SLAVE);
	endproperty
	a_slave: assert property (p_slave) else $error("slave role not chosen");

	property p_row;
		(role_o != ROLE_INNER) |-> (row_select_bit_o == $past(identity_strap_bus_i[3]));
	endproperty
	a_row: assert property (p_row) else $error("row bit wrong");

	property p_ports;
		(differential_control_port_en_o == (role_o != ROLE_OB_SLAVE))
			&& (single_ended_port_en_o == (role_o != ROLE_INNER));
	endproperty
	a_ports: assert property (p_ports) else $error("port enables wrong for role");

	property p_bcast;
		(id_valid_i && match_en && id_byte_i == 8'h0f) |=> write_accept_o;
	endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast write missed");

	property p_mcast;
		(id_valid_i && match_en && role_o != ROLE_INNER
			&& id_byte_i == {1'b0, mod_index_o, ident[3], 3'h7}) |=> write_accept_o;
	endproperty
	a_mcast: assert property (p_mcast) else $error("row multicast missed");

	property p_wb_ack;
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

	// With matching switched off no byte, not even the broadcast, may be taken.
	property p_refused;
		(id_valid_i && !match_en) |=> !write_accept_o;
	endproperty
	a_refused: assert property (p_refused) else $error("write accepted while matching is off");

	// An accept pulse always follows a valid byte; nothing is taken from an idle cycle.
	property p_idle;
		!id_valid_i |=> !write_accept_o;
	endproperty
	a_idle: assert property (p_idle) else $error("write accepted without a byte");

	c_inner:  cover property (role_o == ROLE_INNER ##1 role_o == ROLE_INNER);
	c_master: cover property (role_o == ROLE_OB_MASTER);
	c_slave:  cover property (role_o == ROLE_OB_SLAVE && write_accept_o);
	c_bcast:  cover property (id_valid_i && id_byte_i == 8'h0f ##1 write_accept_o);

endmodule
`default_nettype wire

// >>> hw/id_match.sv
`default_nettype none
module id_match
	import role_pkg::*;
(
	// Own identity.
	input  wire logic [ID_W-1:0] ident_i,
	input  wire decoded_s        dec_i,
	// Chip identification byte of a write.
	input  wire logic [7:0]      id_byte_i,
	// Match results.
	output logic                 unicast_o,
	output logic                 broadcast_o,
	output logic                 multicast_o
);

	// Outer barrel chips also answer to the row multicast of their module.
	wire logic        is_outer = (dec_i.role != ROLE_INNER);
	wire logic [7:0]  row_code = {1'b0, dec_i.mod_index, dec_i.row_select_bit, POS_RESERVED};

	assign unicast_o   = (id_byte_i == {1'b0, ident_i});
	assign broadcast_o = (id_byte_i == GLOBAL_BCAST);
	assign multicast_o = is_outer && (id_byte_i == row_code);

endmodule
`default_nettype wire

// >>> inc/role_pkg.sv
`default_nettype none
package role_pkg;

	// Identity strap layout.
	localparam int ID_W         = 7;
	localparam int MOD_HI       = 6;
	localparam int MOD_LO       = 4;
	localparam int ROW_BIT      = 3;
	localparam int POS_HI       = 2;
	localparam int POS_LO       = 0;

	// Codes with a fixed meaning on the control bus.
	localparam logic [2:0] MOD_INNER      = 3'h0;
	localparam logic [2:0] POS_OB_MASTER  = 3'h0;
	localparam logic [2:0] POS_RESERVED   = 3'h7;
	localparam logic [3:0] IB_RESERVED    = 4'hf;
	localparam logic [7:0] GLOBAL_BCAST   = 8'h0f;

	// Register offsets (byte addresses) and reset values.
	localparam logic [3:0] OFS_STATUS     = 4'h0;
	localparam logic [3:0] OFS_CONTROL    = 4'h4;
	localparam logic [3:0] OFS_HIT_COUNT  = 4'h8;
	localparam logic [6:0] IDENT_RESET    = 7'h00;
	localparam logic       MATCH_EN_RESET = 1'b1;

	// Status and control register field positions, hit counter width.
	localparam int ST_ID_LO       = 0;
	localparam int ST_ROLE_LO     = 7;
	localparam int ST_RSV_BIT     = 10;
	localparam int CTL_MATCH_BIT  = 0;
	localparam int HIT_W          = 16;

	// Operating roles, one-hot.
	typedef enum logic [2:0] {
		ROLE_INNER     = 3'b001,
		ROLE_OB_MASTER = 3'b010,
		ROLE_OB_SLAVE  = 3'b100
	} role_e;

	// Everything derived from the strapped identity.
	typedef struct packed {
		role_e      role;
		logic [2:0] mod_index;
		logic       row_select_bit;
		logic [3:0] position;
		logic       reserved_code;
	} decoded_s;

	// Module index field of an identity.
	function automatic logic [2:0] mod_index_f(input logic [ID_W-1:0] id);
		return id[MOD_HI:MOD_LO];
	endfunction

	// Role chosen by an identity.
	function automatic role_e role_f(input logic [ID_W-1:0] id);
		if (mod_index_f(id) == MOD_INNER) begin
			return ROLE_INNER;
		end else if (id[POS_HI:POS_LO] == POS_OB_MASTER) begin
			return ROLE_OB_MASTER;
		end
		return ROLE_OB_SLAVE;
	endfunction

endpackage
`default_nettype wire
